// ---- rtl/sdic_top.sv ----
// sdic_top: supply domain isolation, backup switch, backup protection and charging.
// assumes synchronous inputs, comparator outputs from the analog front end, one clock.
`timescale 1ns/1ps
module sdic_top #(
    parameter int TEMPO_CYC = sdic_pkg::STARTUP_TEMPO_CYC
) (
    // clock and resets
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_sys_rst_n,
    // software control bits
    input wire sdic_pkg::sdic_ctrl_t i_ctrl,
    // supplies and comparators
    input wire logic i_main_ok,
    input wire logic i_io_rail_cmp,
    input wire logic i_usb_cmp,
    // backup domain write port and read index
    input wire sdic_pkg::sdic_bkp_wr_t i_bkp_wr,
    input wire logic [sdic_pkg::BKP_IDX_W-1:0] i_bkp_rd_idx,
    // port c backup pin requests while on main supply
    input wire logic [2:0] i_pc_gpio_req,
    // isolation
    output logic o_io_rail_iso_n,
    output logic o_usb_iso_n,
    // monitors
    output logic o_io_rail_supply_monitor,
    output logic o_usb_supply_monitor,
    // backup switch
    output logic o_on_battery,
    output logic o_pdr_seen,
    // pin ownership
    output logic [5:0] o_pc_owner,
    output logic o_tamper_enable,
    // backup domain
    output logic o_bkp_locked,
    output logic o_rtc_clock_enable,
    output logic [31:0] o_bdc,
    output logic [31:0] o_bkp_rd_data,
    output logic o_wr_dropped,
    // charging
    output logic o_charge_on,
    output logic o_charge_res_1k5
);
    import sdic_pkg::*;

    logic sw_batt;
    logic sw_pdr;
    logic io_present;
    logic usb_present;
    logic [31:0] bkp [BKP_WORDS];
    logic [31:0] next_bkp [BKP_WORDS];
    logic [31:0] next_bdc;
    logic wr_ok;
    logic next_iso_io_n;
    logic next_iso_usb_n;
    logic [5:0] next_pc_owner;
    logic next_charge_on;
    logic next_wr_dropped;
    logic sys_rst_seen;
    logic next_sys_rst_seen;

    sdic_supply_switch #(
        .TEMPO_CYC(TEMPO_CYC)
    ) u_switch (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_main_ok(i_main_ok),
        .o_on_battery(sw_batt),
        .o_pdr_seen(sw_pdr)
    );

    // comparator threshold (3/4 reference) sits in the analog front end
    sdic_rail_monitor u_io_mon (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_cmp_above(i_io_rail_cmp),
        .o_present(io_present)
    );

    // comparator threshold (full reference) sits in the analog front end
    sdic_rail_monitor u_usb_mon (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_cmp_above(i_usb_cmp),
        .o_present(usb_present)
    );

    // a system reset re-locks the domain even if software left write access set
    always_comb begin
        next_sys_rst_seen = sys_rst_seen;
        if (!i_sys_rst_n) begin
            next_sys_rst_seen = 1'b1;
        end else if (!i_ctrl.backup_write_access) begin
            next_sys_rst_seen = 1'b0;
        end
    end

    assign wr_ok = sdic_bkp_write_ok(i_ctrl) & !sys_rst_seen & i_sys_rst_n;

    // isolation follows release bits; system reset isolates again
    always_comb begin
        next_iso_io_n = i_sys_rst_n & i_ctrl.io_rail_isolation_release;
        next_iso_usb_n = i_sys_rst_n & i_ctrl.usb_rail_isolation_release;
    end

    // two bits per pin: gpio or rtc owner
    always_comb begin
        next_pc_owner = '0;
        for (int p = 0; p < 3; p++) begin
            if (!sw_batt && i_pc_gpio_req[p]) begin
                next_pc_owner[2*p +: 2] = PC_OWN_GPIO;
            end else begin
                next_pc_owner[2*p +: 2] = PC_OWN_RTC;
            end
        end
    end

    // backup writes; protection silently drops, flag shows the drop
    always_comb begin
        next_bdc = o_bdc;
        next_wr_dropped = 1'b0;
        for (int k = 0; k < BKP_WORDS; k++) begin
            next_bkp[k] = bkp[k];
        end
        if (i_bkp_wr.valid) begin
            if (!wr_ok) begin
                next_wr_dropped = 1'b1;
            end else if (i_bkp_wr.is_bdc) begin
                next_bdc = i_bkp_wr.data;
            end else begin
                next_bkp[i_bkp_wr.idx] = i_bkp_wr.data;
            end
        end
    end

    // charging needs main supply, enable bit and not battery mode
    always_comb begin
        next_charge_on = i_main_ok & i_ctrl.battery_charge_enable & !sw_batt;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_rst_seen <= 1'b1;
            o_io_rail_iso_n <= 1'b0;
            o_usb_iso_n <= 1'b0;
            o_io_rail_supply_monitor <= 1'b0;
            o_usb_supply_monitor <= 1'b0;
            o_on_battery <= 1'b1;
            o_pdr_seen <= 1'b0;
            o_pc_owner <= {PC_OWN_RTC, PC_OWN_RTC, PC_OWN_RTC};
            o_tamper_enable <= 1'b1;
            o_bkp_locked <= 1'b1;
            o_rtc_clock_enable <= 1'b0;
            o_bdc <= BDC_RESET;
            o_bkp_rd_data <= 32'h0;
            o_wr_dropped <= 1'b0;
            o_charge_on <= 1'b0;
            o_charge_res_1k5 <= CHG_RES_5K;
            for (int k = 0; k < BKP_WORDS; k++) begin
                bkp[k] <= 32'h0;
            end
        end else begin
            sys_rst_seen <= next_sys_rst_seen;
            o_io_rail_iso_n <= next_iso_io_n;
            o_usb_iso_n <= next_iso_usb_n;
            o_io_rail_supply_monitor <= io_present;
            o_usb_supply_monitor <= usb_present;
            o_on_battery <= sw_batt;
            o_pdr_seen <= sw_pdr;
            o_pc_owner <= next_pc_owner;
            o_tamper_enable <= sw_batt;
            o_bkp_locked <= !wr_ok;
            o_rtc_clock_enable <= next_bdc[RTC_EN_BIT];
            o_bdc <= next_bdc;
            o_bkp_rd_data <= bkp[i_bkp_rd_idx];
            o_wr_dropped <= next_wr_dropped;
            o_charge_on <= next_charge_on;
            o_charge_res_1k5 <= i_ctrl.charge_resistor_select ? CHG_RES_1K5 : CHG_RES_5K;
            for (int k = 0; k < BKP_WORDS; k++) begin
                bkp[k] <= next_bkp[k];
            end
        end
    end
endmodule : sdic_top

// ---- shared/sdic_pkg.sv ----
// sdic_pkg: shared types and constants of the supply domain isolation control block.
// assumes one synchronous clock domain and digital comparator results from the analog front end.
package sdic_pkg;
    // startup temporization in ns, default value; parameterised at top
    localparam int STARTUP_TEMPO_NS = 20000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int STARTUP_TEMPO_CYC = (STARTUP_TEMPO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // power-down reset filter: main supply must stay low this many cycles
    localparam int PDR_FILTER_CYC = 4;
    localparam logic [2:0] PDR_FILTER_MAX = 3'h4;
    // rtc clock enable bit position in backup domain control
    localparam int RTC_EN_BIT = 15;
    // backup domain control reset value
    localparam logic [31:0] BDC_RESET = 32'h0000_0000;
    // backup register count and index width
    localparam int BKP_WORDS = 8;
    localparam int BKP_IDX_W = 3;
    // pin owner codes for the three backup port c pins
    localparam logic [1:0] PC_OWN_GPIO = 2'h0;
    localparam logic [1:0] PC_OWN_RTC = 2'h1;
    // charge resistor select values
    localparam logic CHG_RES_5K = 1'b0;
    localparam logic CHG_RES_1K5 = 1'b1;

    typedef enum logic [1:0] {
        SDIC_SW_TEMPO = 2'b00,
        SDIC_SW_MAIN = 2'b01,
        SDIC_SW_BATT = 2'b10
    } sdic_sw_state_t;

    // software control bits
    typedef struct packed {
        logic io_rail_isolation_release;
        logic usb_rail_isolation_release;
        logic backup_write_access;
        logic battery_charge_enable;
        logic charge_resistor_select;
        logic power_interface_clock_enable;
    } sdic_ctrl_t;

    // backup domain write request
    typedef struct packed {
        logic valid;
        logic is_bdc;
        logic [BKP_IDX_W-1:0] idx;
        logic [31:0] data;
    } sdic_bkp_wr_t;

    function automatic logic sdic_bkp_write_ok(input sdic_ctrl_t c);
        return c.backup_write_access & c.power_interface_clock_enable;
    endfunction : sdic_bkp_write_ok
endpackage : sdic_pkg

// ---- rtl/sdic_supply_switch.sv ----
// sdic_supply_switch: backup domain supply switch between main supply and battery.
// assumes i_main_ok is a synchronous power-good level from the reset block.
`timescale 1ns/1ps
module sdic_supply_switch #(
    parameter int TEMPO_CYC = sdic_pkg::STARTUP_TEMPO_CYC
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // supply status
    input wire logic i_main_ok,
    // switch state
    output logic o_on_battery,
    output logic o_pdr_seen
);
    import sdic_pkg::*;

    sdic_sw_state_t state;
    sdic_sw_state_t next_state;
    logic [31:0] tempo;
    logic [31:0] next_tempo;
    logic [2:0] low_cnt;
    logic [2:0] next_low_cnt;
    logic power_down_reset;

    // short glitches on main supply are filtered before declaring power-down
    assign power_down_reset = (low_cnt == PDR_FILTER_MAX);

    always_comb begin
        next_state = state;
        next_tempo = tempo;
        next_low_cnt = i_main_ok ? 3'h0 : (power_down_reset ? low_cnt : low_cnt + 3'h1);
        case (state)
            SDIC_SW_TEMPO: begin
                if (!i_main_ok) begin
                    next_tempo = 32'h0;
                end else if (tempo >= 32'(TEMPO_CYC - 1)) begin
                    next_state = SDIC_SW_MAIN;
                end else begin
                    next_tempo = tempo + 32'h1;
                end
            end
            SDIC_SW_MAIN: begin
                if (power_down_reset) begin
                    next_state = SDIC_SW_BATT;
                end
            end
            SDIC_SW_BATT: begin
                if (i_main_ok) begin
                    next_state = SDIC_SW_TEMPO;
                    next_tempo = 32'h0;
                end
            end
            default: begin
                next_state = SDIC_SW_TEMPO;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= SDIC_SW_TEMPO;
            tempo <= 32'h0;
            low_cnt <= 3'h0;
            o_on_battery <= 1'b1;
            o_pdr_seen <= 1'b0;
        end else begin
            state <= next_state;
            tempo <= next_tempo;
            low_cnt <= next_low_cnt;
            o_on_battery <= (next_state != SDIC_SW_MAIN);
            o_pdr_seen <= (next_state == SDIC_SW_BATT);
        end
    end
endmodule : sdic_supply_switch

// ---- rtl/sdic_rail_monitor.sv ----
// sdic_rail_monitor: debounced supply presence from an analog comparator output.
// assumes the comparator threshold is fixed in the analog front end.
`timescale 1ns/1ps
module sdic_rail_monitor (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // comparator
    input wire logic i_cmp_above,
    // result
    output logic o_present
);
    import sdic_pkg::*;

    logic [1:0] hist;
    logic [1:0] next_hist;
    logic next_present;

    // two agreeing samples needed; a one-sample glitch will not toggle presence
    always_comb begin
        next_hist = {hist[0], i_cmp_above};
        next_present = o_present;
        if (next_hist == 2'h3) begin
            next_present = 1'b1;
        end else if (next_hist == 2'h0) begin
            next_present = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hist <= 2'h0;
            o_present <= 1'b0;
        end else begin
            hist <= next_hist;
            o_present <= next_present;
        end
    end
endmodule : sdic_rail_monitor

// ---- verif/sdic_top_asserts.sv ----
// sdic_top_asserts: port-level checks of the isolation control block.
// assumes it is bound to sdic_top, one clock, async reset.
`timescale 1ns/1ps
module sdic_top_asserts (
    // clock and resets
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_sys_rst_n,
    // inputs
    input wire sdic_pkg::sdic_ctrl_t i_ctrl,
    input wire logic i_main_ok,
    input wire sdic_pkg::sdic_bkp_wr_t i_bkp_wr,
    // outputs
    input wire logic o_io_rail_iso_n,
    input wire logic o_usb_iso_n,
    input wire logic o_on_battery,
    input wire logic [5:0] o_pc_owner,
    input wire logic o_tamper_enable,
    input wire logic o_bkp_locked,
    input wire logic o_wr_dropped,
    input wire logic o_charge_on
);
    import sdic_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    chk_io_sys_iso: assert property (!i_sys_rst_n |-> ##[1:3] !o_io_rail_iso_n)
        else $error("io rail not isolated by system reset");
    chk_usb_sys_iso: assert property (!i_sys_rst_n |-> ##[1:3] !o_usb_iso_n)
        else $error("usb not isolated by system reset");
    chk_io_iso_bit: assert property
        (!i_ctrl.io_rail_isolation_release [*4] |-> !o_io_rail_iso_n)
        else $error("io rail released without its bit");
    chk_usb_iso_bit: assert property
        (!i_ctrl.usb_rail_isolation_release [*4] |-> !o_usb_iso_n)
        else $error("usb released without its bit");
    chk_pdr_to_batt: assert property (!i_main_ok [*6] |-> ##[0:3] o_on_battery)
        else $error("no switch to battery on power loss");
    chk_batt_no_chg: assert property (o_on_battery [*3] |-> !o_charge_on)
        else $error("charging while on battery");
    chk_batt_pc_rtc: assert property (o_on_battery [*3] |-> o_pc_owner == 6'h15)
        else $error("port c pins not owned by rtc on battery");
    chk_batt_tamper: assert property (o_on_battery [*3] |-> o_tamper_enable)
        else $error("tamper inputs off on battery");
    chk_drop_locked: assert property
        (i_bkp_wr.valid && o_bkp_locked && $past(o_bkp_locked) |=> o_wr_dropped)
        else $error("locked write not dropped");
    chk_chg_needs_en: assert property
        (!i_ctrl.battery_charge_enable [*4] |-> !o_charge_on)
        else $error("charging without enable");
endmodule : sdic_top_asserts

// ---- verif/tb.sv ----
// tb: self-checking bench for sdic_top, inputs driven at the falling edge.
// assumes a shortened startup delay so the run stays short.
`timescale 1ns/1ps
module tb;
    import sdic_pkg::*;
    localparam int TEMPO = 20;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_sys_rst_n = 1'b0;
    sdic_ctrl_t i_ctrl = '0;
    logic i_main_ok = 1'b1;
    logic i_io_rail_cmp = 1'b1;
    logic i_usb_cmp = 1'b1;
    sdic_bkp_wr_t i_bkp_wr = '0;
    logic [2:0] i_bkp_rd_idx = 3'h0;
    logic [2:0] i_pc_gpio_req = 3'h5;
    logic io_iso_n, usb_iso_n, io_mon, usb_mon, on_batt, power_down_reset, tamper, locked;
    logic rtc_en, dropped, chg_on, chg_1k5, d;
    logic [5:0] pc_owner;
    logic [31:0] bdc, rd_data;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2 i_mclk = ~i_mclk;
    sdic_top #(.TEMPO_CYC(TEMPO)) dut (.i_mclk, .i_rst_n, .i_sys_rst_n, .i_ctrl, .i_main_ok,
        .i_io_rail_cmp, .i_usb_cmp, .i_bkp_wr, .i_bkp_rd_idx, .i_pc_gpio_req,
        .o_io_rail_iso_n(io_iso_n), .o_usb_iso_n(usb_iso_n), .o_io_rail_supply_monitor(io_mon),
        .o_usb_supply_monitor(usb_mon), .o_on_battery(on_batt), .o_pdr_seen(power_down_reset),
        .o_pc_owner(pc_owner), .o_tamper_enable(tamper), .o_bkp_locked(locked),
        .o_rtc_clock_enable(rtc_en), .o_bdc(bdc), .o_bkp_rd_data(rd_data),
        .o_wr_dropped(dropped), .o_charge_on(chg_on), .o_charge_res_1k5(chg_1k5));
    task automatic cyc(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : cyc
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // drop flag caught over two samples; exact timing is left to the checker
    task automatic wr(input logic sel, input logic [2:0] idx, input logic [31:0] v);
        i_bkp_wr = '{1'b1, sel, idx, v};
        cyc(1);
        i_bkp_wr.valid = 1'b0;
        d = dropped;
        cyc(1);
        d = d | dropped;
    endtask : wr
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic t_reset;
        chk("io_iso", 0, io_iso_n);
        chk("usb_iso", 0, usb_iso_n);
        chk("pc_owner", 6'h15, pc_owner);
        chk("locked", 1, locked);
        chk("bdc", 0, bdc);
        $display("done reset");
    endtask : t_reset
    task automatic t_startup;
        cyc(TEMPO - 4);
        chk("tempo_batt", 1, on_batt);
        cyc(10);
        chk("main_batt", 0, on_batt);
        chk("pc_gpio", 6'h04, pc_owner);
        $display("done startup");
    endtask : t_startup
    task automatic t_iso;
        chk("io_held", 0, io_iso_n);
        chk("usb_held", 0, usb_iso_n);
        chk("io_mon", 1, io_mon);
        chk("usb_mon", 1, usb_mon);
        // release only once the rails are seen present
        i_ctrl.io_rail_isolation_release = 1'b1;
        i_ctrl.usb_rail_isolation_release = 1'b1;
        cyc(4);
        chk("io_rel", 1, io_iso_n);
        chk("usb_rel", 1, usb_iso_n);
        i_sys_rst_n = 1'b0;
        cyc(4);
        chk("io_sys", 0, io_iso_n);
        chk("usb_sys", 0, usb_iso_n);
        i_sys_rst_n = 1'b1;
        i_ctrl.io_rail_isolation_release = 1'b0;
        i_ctrl.usb_rail_isolation_release = 1'b0;
        i_io_rail_cmp = 1'b0;
        i_usb_cmp = 1'b0;
        cyc(6);
        chk("io_mon_lo", 0, io_mon);
        chk("usb_mon_lo", 0, usb_mon);
        $display("done isolation");
    endtask : t_iso
    task automatic t_backup;
        i_ctrl.power_interface_clock_enable = 1'b1;
        cyc(2);
        wr(1'b1, 3'h0, 32'h0000_8100);
        chk("drop_lock", 1, d);
        chk("bdc_lock", 0, bdc);
        i_ctrl.backup_write_access = 1'b1;
        cyc(4);
        chk("unlocked", 0, locked);
        wr(1'b1, 3'h0, 32'h0000_0100);
        wr(1'b1, 3'h0, 32'h0000_8100);
        chk("bdc", 32'h0000_8100, bdc);
        chk("rtc_en", 1, rtc_en);
        wr(1'b0, 3'h5, 32'h5a5a_c3c3);
        chk("drop_open", 0, d);
        i_bkp_rd_idx = 3'h5;
        cyc(3);
        chk("bkp5", 32'h5a5a_c3c3, rd_data);
        // system reset with write access still set must relock the domain
        i_sys_rst_n = 1'b0;
        cyc(2);
        i_sys_rst_n = 1'b1;
        cyc(2);
        chk("sys_relock", 1, locked);
        wr(1'b0, 3'h5, 32'h1111_2222);
        chk("drop_sys", 1, d);
        i_ctrl.backup_write_access = 1'b0;
        cyc(4);
        chk("relocked", 1, locked);
        wr(1'b0, 3'h5, 32'h1111_2222);
        cyc(3);
        chk("drop_bkp", 1, d);
        chk("bkp5_kept", 32'h5a5a_c3c3, rd_data);
        $display("done backup");
    endtask : t_backup
    task automatic t_charge;
        i_ctrl.battery_charge_enable = 1'b1;
        cyc(4);
        chk("chg_on", 1, chg_on);
        chk("res_5k", 0, chg_1k5);
        i_ctrl.charge_resistor_select = CHG_RES_1K5;
        cyc(4);
        chk("res_1k5", 1, chg_1k5);
        i_main_ok = 1'b0;
        cyc(10);
        chk("pdr_batt", 1, on_batt);
        chk("pdr_seen", 1, power_down_reset);
        chk("chg_batt", 0, chg_on);
        chk("pc_rtc", 6'h15, pc_owner);
        chk("tamper", 1, tamper);
        i_main_ok = 1'b1;
        cyc(4);
        // main back but still in startup delay: charging must stay off
        chk("tempo_batt2", 1, on_batt);
        chk("chg_tempo", 0, chg_on);
        cyc(2 * TEMPO + 8);
        chk("back_main", 0, on_batt);
        chk("chg_again", 1, chg_on);
        i_ctrl.battery_charge_enable = 1'b0;
        cyc(4);
        chk("chg_off", 0, chg_on);
        $display("done charge");
    endtask : t_charge
    initial begin
        cyc(10);
        t_reset();
        i_rst_n = 1'b1;
        i_sys_rst_n = 1'b1;
        t_startup();
        t_iso();
        t_backup();
        t_charge();
        end_of_test();
    end
endmodule : tb
bind sdic_top sdic_top_asserts u_chk (.i_mclk, .i_rst_n, .i_sys_rst_n, .i_ctrl, .i_main_ok,
    .i_bkp_wr, .o_io_rail_iso_n, .o_usb_iso_n, .o_on_battery, .o_pc_owner, .o_tamper_enable,
    .o_bkp_locked, .o_wr_dropped, .o_charge_on);
